// ==== pkg/ascd_pkg.sv ====
// Shared constants and types for the scan and setup command decoder
package ascd_pkg;
	// Command byte decode
	localparam int CMD_SEL_BIT = 7;
	localparam int SETUP_SEL_BIT = 6;
	localparam int PICK_MSB = 5;
	localparam int PICK_LSB = 3;
	localparam int SWEEP_MSB = 2;
	localparam int SWEEP_LSB = 1;
	localparam int TEMP_BIT = 0;
	localparam int CLK_MSB = 5;
	localparam int CLK_LSB = 4;
	localparam int REF_MSB = 3;
	localparam int REF_LSB = 2;
	localparam int PAIR_MSB = 1;
	localparam int PAIR_LSB = 0;
	// Reset values
	localparam logic [7:0] CONV_RST = 8'h80;
	localparam logic [5:0] SETUP_RST = 6'h28;
	// Timing
	localparam int REF_HOLD_CYCLES = 188;
	localparam int REPEAT_UNIT = 4;
	localparam int BYTE_BITS = 8;

	typedef enum logic [1:0] {
		SWEEP_UP_TO_N,
		SWEEP_FROM_N,
		SWEEP_REPEAT,
		SWEEP_SINGLE
	} ascd_sweep_t;

	typedef enum logic [1:0] {
		CLK_INT_AUTO,
		CLK_INT_PIN,
		CLK_INT_WRITE,
		CLK_SERIAL
	} ascd_clk_t;

	typedef struct packed {
		logic [2:0] pick;
		ascd_sweep_t sweep;
		logic temp;
	} ascd_conv_t;

	typedef struct packed {
		ascd_clk_t clk;
		logic [1:0] ref_mode;
		logic [1:0] pairing;
	} ascd_setup_t;

	typedef struct packed {
		logic strobe;
		logic temp;
		logic [2:0] channel;
	} ascd_req_t;
endpackage : ascd_pkg

// ==== rtl/ascd_decoder.sv ====
// Command byte decoder and scan sequencer for the conversion and setup registers
`timescale 1ns/1ps
// Overview of operation
// - Byte with bit 7 set writes the conversion register; bit 6 ignored.
// - Conversion bits 5..3 give channel number N, zero to seven.
// - Sweep mode 00 converts channels zero through N, plus optional temperature.
// - Sweep mode 01 converts N through highest channel, plus optional temperature.
// - Sweep mode 10 converts N repeatedly; repeat count field sets result number.
// - Sweep mode 11 converts channel N exactly once.
// - Temperature bit adds one temperature result, always first in the scan.
// - Clock modes 10 and 11 start a scan on the conversion write.
// - Clock modes 00 and 01 start a scan on a low convert-start pulse.
// - Channels acting as convert-start or second reference pin are skipped.
// - Differential pairs ignore the lowest pick bit and convert as one.
// - Byte with bit 7 clear and bit 6 set writes setup.
// - Setup bits 5..4 are clock mode; upper bit resets to one.
// - Clock modes 00 and 10 time acquisition internally.
// - Clock mode 01 uses internal clock, acquisition timed by the pin.
// - Clock mode 11 converts from the serial clock, at most 4.8MHz.
// - Shared pin is convert-start in modes 00/01, analog input seven otherwise.
// - Setup bits 3..2 select the reference mode.
// - Setup bits 1..0 select the pairing register and differential inputs.
// - Reference forced on by force bit, or mode 00 with a DAC active.
// - With reference forced on, temperature waits 188 cycles before starting.
// - Reference mode 00 internal; modes 00/10 second reference pin is input.
module ascd_decoder #(
	parameter int NUM_INPUTS = 8,
	parameter int SECOND_REFERENCE_PIN_CHANNEL = 6,
	parameter int PIN_CHANNEL = 7
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic link_sclk,
	input wire logic link_cs_b,
	input wire logic link_mosi,
	input wire logic convert_start_pin_b,
	input wire logic bandgap_force_on,
	input wire logic dac_holds_reference,
	input wire logic [1:0] repeat_count,
	input wire logic conv_ack,
	output ascd_pkg::ascd_req_t conv_req,
	output ascd_pkg::ascd_conv_t conversion_control,
	output ascd_pkg::ascd_setup_t clock_reference_setup,
	output logic shared_pin_is_input,
	output logic second_ref_is_input,
	output logic internal_conv_clock,
	output logic acq_timed_by_pin,
	output logic acq_timed_by_serial,
	output logic adc_reference_on,
	output logic scan_busy,
	output logic scan_done
);
	import ascd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Link side: serial shift register on the link clock
	logic [2:0] bit_cnt_r;
	logic [6:0] shift_r;
	logic [7:0] hold_r;
	logic tog_r;
	wire logic [7:0] full_byte = {shift_r, link_mosi};
	wire logic last_bit = (bit_cnt_r == 3'(BYTE_BITS - 1));

	// Frame end clears the bit count
	always_ff @(posedge link_sclk or posedge link_cs_b) begin
		if (link_cs_b) begin
			bit_cnt_r <= 3'h0;
			shift_r <= 7'h00;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			shift_r <= full_byte[6:0];
		end
	end

	// Completed byte held and announced by toggle
	always_ff @(posedge link_sclk or negedge rst_b) begin
		if (!rst_b) begin
			hold_r <= 8'h00;
			tog_r <= 1'b0;
		end else if (!link_cs_b && last_bit) begin
			hold_r <= full_byte;
			tog_r <= ~tog_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Crossings into the system clock
	logic [2:0] tog_sync_r;
	logic [2:0] pin_sync_r;
	logic [7:0] byte_r;
	logic byte_evt_r;
	wire logic byte_evt_nxt = tog_sync_r[2] ^ tog_sync_r[1];
	wire logic pin_fall = pin_sync_r[2] & ~pin_sync_r[1];

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tog_sync_r <= 3'b000;
			pin_sync_r <= 3'b111;
			byte_r <= 8'h00;
			byte_evt_r <= 1'b0;
		end else begin
			tog_sync_r <= {tog_sync_r[1:0], tog_r};
			pin_sync_r <= {pin_sync_r[1:0], convert_start_pin_b};
			byte_evt_r <= byte_evt_nxt;
			if (byte_evt_nxt) begin
				byte_r <= hold_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command decode and registers
	wire logic conv_write = byte_evt_r & byte_r[CMD_SEL_BIT];
	wire logic setup_write = byte_evt_r & ~byte_r[CMD_SEL_BIT] & byte_r[SETUP_SEL_BIT];
	wire ascd_conv_t conv_nxt = '{
		pick: byte_r[PICK_MSB:PICK_LSB],
		sweep: ascd_sweep_t'(byte_r[SWEEP_MSB:SWEEP_LSB]),
		temp: byte_r[TEMP_BIT]
	};
	wire ascd_setup_t setup_nxt = '{
		clk: ascd_clk_t'(byte_r[CLK_MSB:CLK_LSB]),
		ref_mode: byte_r[REF_MSB:REF_LSB],
		pairing: byte_r[PAIR_MSB:PAIR_LSB]
	};

	ascd_conv_t conv_r;
	ascd_setup_t setup_r;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			conv_r <= ascd_conv_t'(CONV_RST[5:0]);
			setup_r <= ascd_setup_t'(SETUP_RST);
		end else begin
			if (conv_write) begin
				conv_r <= conv_nxt;
			end
			if (setup_write) begin
				setup_r <= setup_nxt;
			end
		end
	end
	assign conversion_control = conv_r;
	assign clock_reference_setup = setup_r;

	////////////////////////////////////////////////////////////////////////////
	// Mode decode
	wire logic pin_mode = ~setup_r.clk[1];
	wire logic second_reference_pin_is_ref = setup_r.ref_mode[0];
	wire logic diff_mode = (setup_r.pairing != 2'b00);
	assign shared_pin_is_input = setup_r.clk[1];
	assign second_ref_is_input = ~second_reference_pin_is_ref;
	assign internal_conv_clock = (setup_r.clk != CLK_SERIAL);
	assign acq_timed_by_pin = (setup_r.clk == CLK_INT_PIN);
	assign acq_timed_by_serial = (setup_r.clk == CLK_SERIAL);

	logic ref_on_r;
	wire logic ref_on_nxt = bandgap_force_on |
		((setup_r.ref_mode == 2'b00) & dac_holds_reference);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_on_r <= 1'b0;
		end else begin
			ref_on_r <= ref_on_nxt;
		end
	end
	assign adc_reference_on = ref_on_r;

	////////////////////////////////////////////////////////////////////////////
	// Scan sequencer
	typedef enum logic [2:0] {S_IDLE, S_REF_WAIT, S_TEMP, S_STEP, S_ACK} ascd_state_t;
	ascd_state_t state_r;
	logic [2:0] ch_r;
	logic [2:0] end_r;
	logic [4:0] reps_r;
	logic [7:0] wait_r;
	logic temp_pend_r;
	logic first_r;
	logic [4:0] nres_r;

	wire logic idle = (state_r == S_IDLE);
	wire logic start = idle & ((conv_write & setup_r.clk[1]) | (pin_fall & pin_mode));
	wire logic [2:0] pair_mask = diff_mode ? 3'b110 : 3'b111;
	wire ascd_conv_t conv_eff = conv_write ? conv_nxt : conv_r;
	wire logic [2:0] n_pick = conv_eff.pick & pair_mask;
	wire logic [2:0] top_ch = 3'(NUM_INPUTS - 1) & pair_mask;
	wire logic [2:0] step = diff_mode ? 3'h2 : 3'h1;
	wire logic [2:0] start_ch = (conv_eff.sweep == SWEEP_UP_TO_N) ? 3'h0 : n_pick;
	wire logic [2:0] stop_ch = (conv_eff.sweep == SWEEP_FROM_N) ? top_ch : n_pick;
	wire logic [4:0] reps_init = (conv_eff.sweep == SWEEP_REPEAT) ?
		5'((32'(repeat_count) + 1) * REPEAT_UNIT) : 5'h01;
	wire logic ch_pin = pin_mode & ((ch_r | ~pair_mask) == 3'(PIN_CHANNEL));
	wire logic ch_second_reference_pin = second_reference_pin_is_ref & ((ch_r | ~pair_mask) == 3'(SECOND_REFERENCE_PIN_CHANNEL) |
		(ch_r & pair_mask) == 3'(SECOND_REFERENCE_PIN_CHANNEL));
	wire logic skip = ch_pin | ch_second_reference_pin;
	wire logic repeat_mode = (conv_r.sweep == SWEEP_REPEAT) |
		(conv_r.sweep == SWEEP_SINGLE);
	wire logic last_one = repeat_mode ? (reps_r == 5'h01) : (ch_r == end_r);
	wire logic [7:0] hold_cycles = 8'(REF_HOLD_CYCLES);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= S_IDLE;
			ch_r <= 3'h0;
			end_r <= 3'h0;
			reps_r <= 5'h00;
			wait_r <= 8'h00;
			temp_pend_r <= 1'b0;
			first_r <= 1'b0;
		end else begin
			unique case (state_r)
				S_IDLE: begin
					if (start) begin
						ch_r <= start_ch;
						end_r <= stop_ch;
						reps_r <= reps_init;
						temp_pend_r <= conv_eff.temp;
						first_r <= 1'b1;
						wait_r <= hold_cycles;
						if (!conv_eff.temp) begin
							state_r <= S_STEP;
						end else if (ref_on_r) begin
							state_r <= S_REF_WAIT;
						end else begin
							state_r <= S_TEMP;
						end
					end
				end
				S_REF_WAIT: begin
					wait_r <= wait_r - 8'h01;
					if (wait_r == 8'h01) begin
						state_r <= S_TEMP;
					end
				end
				S_TEMP: begin
					state_r <= S_ACK;
				end
				S_STEP: begin
					if (skip) begin
						if (last_one) begin
							state_r <= S_IDLE;
						end else if (repeat_mode) begin
							reps_r <= reps_r - 5'h01;
						end else begin
							ch_r <= ch_r + step;
						end
					end else begin
						state_r <= S_ACK;
					end
				end
				S_ACK: begin
					if (conv_ack) begin
						first_r <= 1'b0;
						if (temp_pend_r) begin
							temp_pend_r <= 1'b0;
							state_r <= S_STEP;
						end else if (last_one) begin
							state_r <= S_IDLE;
						end else begin
							state_r <= S_STEP;
							if (repeat_mode) begin
								reps_r <= reps_r - 5'h01;
							end else begin
								ch_r <= ch_r + step;
							end
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Request outputs
	ascd_req_t req_r;
	logic done_r;
	wire logic leave_scan = ~idle & ((state_r == S_ACK & conv_ack & ~temp_pend_r & last_one) |
		(state_r == S_STEP & skip & last_one));
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_r <= '0;
			done_r <= 1'b0;
		end else begin
			req_r.strobe <= (state_r == S_TEMP) | (state_r == S_STEP & ~skip);
			req_r.temp <= (state_r == S_TEMP);
			req_r.channel <= ch_r;
			done_r <= leave_scan;
		end
	end
	assign conv_req = req_r;
	assign scan_busy = ~idle;
	assign scan_done = done_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			nres_r <= 5'h00;
		end else if (start) begin
			nres_r <= 5'h00;
		end else if (req_r.strobe) begin
			nres_r <= nres_r + 5'h01;
		end
	end

	conv_write_a: assert property (conv_write |=> conv_r.pick == $past(byte_r[5:3]))
		else $error("conversion write lost");
	setup_write_a: assert property (setup_write |=> setup_r == $past(byte_r[5:0]))
		else $error("setup write lost");
	write_start_a: assert property (idle && conv_write && setup_r.clk[1] |=> !idle)
		else $error("write did not start scan");
	pin_start_a: assert property (idle && pin_fall && pin_mode |=> !idle)
		else $error("pin pulse did not start scan");
	pin_ignored_a: assert property (idle && !conv_write && setup_r.clk[1] |=> idle)
		else $error("scan started without write");
	skip_reserved_a: assert property (state_r == S_STEP && skip |=> !req_r.strobe)
		else $error("reserved channel converted");
	diff_pair_a: assert property (req_r.strobe && !req_r.temp && diff_mode
		|-> !req_r.channel[0])
		else $error("odd channel in differential");
	temp_first_a: assert property (state_r == S_TEMP |-> first_r ##1 req_r.temp)
		else $error("temperature not first");
	ref_wait_a: assert property (idle && start && conv_eff.temp && ref_on_r
		|=> (state_r == S_REF_WAIT)[*8])
		else $error("temperature wait too short");
	single_a: assert property (done_r && conv_r.sweep == SWEEP_SINGLE && !conv_r.temp
		|-> nres_r <= 5'h01)
		else $error("single mode gave extra results");
	ref_on_a: assert property (bandgap_force_on |=> adc_reference_on)
		else $error("reference not forced on");

	// Cycles spent in the reference wait
	logic [7:0] ref_cnt_r;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_cnt_r <= 8'h00;
		end else if (state_r == S_REF_WAIT) begin
			ref_cnt_r <= ref_cnt_r + 8'h01;
		end else begin
			ref_cnt_r <= 8'h00;
		end
	end

	ref_hold_a: assert property (state_r == S_REF_WAIT ##1 state_r == S_TEMP
		|-> $past(ref_cnt_r) == 8'(REF_HOLD_CYCLES - 1))
		else $error("temperature wait length wrong");
	ref_dac_a: assert property (setup_r.ref_mode == 2'b00 && dac_holds_reference |=> adc_reference_on)
		else $error("reference not held on for DAC");
	sweep_end_a: assert property (state_r == S_STEP && !repeat_mode |-> ch_r <= end_r)
		else $error("sweep ran past its end");
	req_pulse_a: assert property (req_r.strobe |=> !req_r.strobe)
		else $error("request longer than one cycle");
	done_idle_a: assert property (done_r |-> idle)
		else $error("done while scan still busy");
	setup_hold_a: assert property (!setup_write |=> $stable(setup_r))
		else $error("setup changed without write");
	conv_hold_a: assert property (!conv_write |=> $stable(conv_r))
		else $error("conversion changed without write");
	skip_pin_a: assert property (req_r.strobe && !req_r.temp && pin_mode
		|-> req_r.channel != 3'(PIN_CHANNEL))
		else $error("convert-start channel converted");

	scan_up_c: cover property (start && conv_eff.sweep == SWEEP_UP_TO_N ##[1:200] done_r);
	temp_wait_c: cover property (state_r == S_REF_WAIT ##[1:300] state_r == S_TEMP);
	repeat_c: cover property (start && conv_eff.sweep == SWEEP_REPEAT ##[1:400] done_r);
	pin_start_c: cover property (start && pin_mode ##[1:400] done_r);
	diff_c: cover property (req_r.strobe && diff_mode && !req_r.temp);
endmodule : ascd_decoder

// ==== verification/ascd_host_model.sv ====
// Host model driving the serial command link
`timescale 1ns/1ps
module ascd_host_model (
	output logic link_sclk,
	output logic link_cs_b,
	output logic link_mosi
);
	initial begin
		link_sclk = 1'b0;
		link_cs_b = 1'b1;
		link_mosi = 1'b0;
	end
	// Top nbits of data, MSB first, one frame; clock still outside it
	task automatic send(input logic [7:0] data, input int nbits);
		link_cs_b = 1'b0;
		for (int i = 7; i > 7 - nbits; i--) begin
			link_mosi = data[i];
			#15 link_sclk = 1'b1;
			#15 link_sclk = 1'b0;
		end
		#15 link_cs_b = 1'b1;
		link_mosi = ~link_mosi;
		#200;
	endtask : send
endmodule : ascd_host_model

// ==== verification/adc_scan_setup_command_decode_bench.sv ====
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module adc_scan_setup_command_decode_bench;
	import ascd_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic pin_b = 1'b1;
	logic bg = 1'b0;
	logic dac = 1'b0;
	logic [1:0] rc = 2'b00;
	logic conv_ack = 1'b0;
	wire sclk;
	wire cs_b;
	wire mosi;
	ascd_req_t req;
	ascd_conv_t conv;
	ascd_setup_t setup;
	logic sh_in, r2_in, int_clk, by_pin, by_ser, ref_on, busy, done;
	logic [5:0] sm;
	int n_errors = 0;
	int num_checks = 0;
	int n_done = 0;
	logic [3:0] got_q[$];
	logic [3:0] exp_q[$];

	always #25 sys_clk = ~sys_clk;

	ascd_host_model host (.link_sclk(sclk), .link_cs_b(cs_b), .link_mosi(mosi));
	ascd_decoder DUT (.sys_clk(sys_clk), .rst_b(rst_b), .link_sclk(sclk), .link_cs_b(cs_b),
		.link_mosi(mosi), .convert_start_pin_b(pin_b), .bandgap_force_on(bg),
		.dac_holds_reference(dac), .repeat_count(rc), .conv_ack(conv_ack), .conv_req(req),
		.conversion_control(conv), .clock_reference_setup(setup), .shared_pin_is_input(sh_in),
		.second_ref_is_input(r2_in), .internal_conv_clock(int_clk), .acq_timed_by_pin(by_pin),
		.acq_timed_by_serial(by_ser), .adc_reference_on(ref_on), .scan_busy(busy),
		.scan_done(done));

	////////////////////////////////////////////////////////////////////////////////
	// Converter stand-in: records requests, acknowledges after a random wait
	initial forever begin
		@(negedge sys_clk);
		if (req.strobe === 1'b1) begin
			got_q.push_back(req.temp ? 4'h8 : {1'b0, req.channel});
			repeat ($urandom_range(1, 4)) @(posedge sys_clk);
			#1 conv_ack = 1'b1;
			@(posedge sys_clk);
			#1 conv_ack = 1'b0;
		end
	end

	// Scan completions, sampled mid-cycle
	always @(negedge sys_clk) begin
		if (done === 1'b1) n_done++;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", what, e, g);
		end
	endtask : check

	task automatic final_report();
		$display("Checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] b);
		host.send(b, 8);
		tick(8);
	endtask : wr

	// Channel taken by the convert-start or second reference pin
	function automatic bit rsv(input int ch);
		return (ch == 7 && !sm[5]) || (ch == 6 && sm[2]);
	endfunction : rsv

	function automatic void expect_scan(input logic [5:0] c);
		int n = c[5:3];
		int st = (sm[1:0] != 2'b00) ? 2 : 1;
		int lo;
		int hi;
		exp_q.delete();
		if (st == 2) n = n & 6;
		lo = (c[2:1] == 2'b00) ? 0 : n;
		hi = (c[2:1] == 2'b01) ? 7 : n;
		if (c[0]) exp_q.push_back(4'h8);
		if (c[2:1] == 2'b10) begin
			if (!rsv(n) && !rsv(n + st - 1)) repeat (4 * (rc + 1)) exp_q.push_back(4'(n));
		end else begin
			for (int ch = lo; ch <= hi; ch += st)
				if (!rsv(ch) && !rsv(ch + st - 1)) exp_q.push_back(4'(ch));
		end
	endfunction : expect_scan

	task automatic scan(input logic [7:0] cmd);
		int n0;
		n0 = n_done;
		got_q.delete();
		expect_scan(cmd[5:0]);
		if (sm[5]) host.send(cmd, 8);
		else begin
			wr(cmd);
			pin_b = 1'b0;
			tick(3);
			pin_b = 1'b1;
		end
		for (int i = 0; i < 1500 && n_done == n0; i++) @(negedge sys_clk);
		tick(2);
		check("scan done", 32'h1, n_done - n0);
		check("conv reg", cmd[5:0], {26'h0, conv});
		check("count", exp_q.size(), got_q.size());
		foreach (exp_q[i]) check("result", exp_q[i], got_q[i]);
	endtask : scan

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int k;
		logic [4:0] fl;
		void'($urandom(32'h2B367C1C));
		sm = SETUP_RST;
		tick(10);
		rst_b = 1'b1;
		tick(2);
		check("setup rst", SETUP_RST, {26'h0, setup});
		check("conv rst", 32'h0, {26'h0, conv});
		host.send(8'h7F, 5);
		wr(8'h3F);
		check("ignored", SETUP_RST, {26'h0, setup});
		pin_b = 1'b0;
		tick(3);
		pin_b = 1'b1;
		tick(4);
		check("pin ignored", 32'h0, busy);
		sm = 6'h20;
		wr(8'h60);
		bg = 1'b1;
		tick(4);
		host.send(8'h9F, 8);
		for (int i = 0; i < 500 && busy !== 1'b1; i++) @(negedge sys_clk);
		for (k = 0; k < 500 && req.strobe !== 1'b1; k++) @(negedge sys_clk);
		check("temp wait", 32'h1, k >= REF_HOLD_CYCLES && k < REF_HOLD_CYCLES + 4);
		tick(20);
		for (int i = 0; i < 32; i++) begin
			sm = 6'($urandom);
			wr({2'b01, sm});
			{bg, dac, rc} = 4'($urandom);
			tick(4);
			check("setup", sm, {26'h0, setup});
			fl = {sm[5], !sm[2], sm[5:4] != 2'b11, sm[5:4] == 2'b01, sm[5:4] == 2'b11};
			check("flags", fl, {sh_in, r2_in, int_clk, by_pin, by_ser});
			check("ref on", bg | (sm[3:2] == 2'b00 & dac), ref_on);
			scan({1'b1, 1'($urandom), 3'($urandom), 2'(i), 1'($urandom)});
		end
		final_report();
	end

	initial begin
		#4_000_000;
		n_errors++;
		final_report();
	end
endmodule : adc_scan_setup_command_decode_bench
